// file: hdl/sar_pkg.sv
// Shared constants and types of the conversion sequencer.
// Assumes a single 25 MHz system clock.
package sar_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int          RES_W      = 12;
  localparam int          IDX_W      = 4;
  localparam int          FIFO_DEPTH = 8;
  localparam int          CLK_NS     = 40;
  localparam int          BIT_NS     = 200;
  localparam int          BIT_CYC    = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W      = 4;
  localparam int          ACQ_NS     = 600;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam logic [IDX_W-1:0] MSB_IDX   = 4'hb;
  localparam logic [IDX_W-1:0] LSB_IDX   = 4'h0;
  localparam logic [RES_W-1:0] MSB_MASK  = 12'h800;
  localparam logic [RES_W-1:0] ZERO_WORD = 12'h000;
  localparam logic [3:0]       LOW_NIB   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
  localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(BIT_CYC - 1);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CONV = 3'b010,
    S_LOAD = 3'b100
  } seq_state_t;

endpackage

// file: hdl/stream_if.sv
// Valid/ready word stream between the sequencer and its result FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 12);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: hdl/result_fifo.sv
// Result FIFO, parameterised in width and depth.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Streams
  stream_if.snk     wr,
  stream_if.src     rd
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_st_t;

  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     push;
  logic     pop;

  assign wr.ready = (st_q.cnt != (AW+1)'(D));
  assign rd.valid = (st_q.cnt != '0);
  assign rd.data  = st_q.mem[st_q.rp];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = wr.data;
      st_d.wp = (st_q.wp == AW'(D-1)) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == AW'(D-1)) ? '0 : st_q.rp + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  chk_fifo_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.cnt <= (AW+1)'(D))
    else $error("fifo count exceeds depth");
endmodule
`default_nettype wire

// file: hdl/sar_conversion_sequencer.sv
// Control logic of a 12-bit successive-approximation converter.
// Assumes host strobes and comparator decision synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Start clears the approximation register and enables data drivers.
// - Start requests are ignored while a conversion runs.
// - Trial bits step MSB to LSB; comparator keeps or clears each.
// - After the last decision the word is copied to the output latches.
// - Result bit 11 is the MSB, bit 0 the LSB.
// - Unipolar mode outputs straight binary, step full scale over 4096.
// - Bipolar mode outputs two's complement.
// - Acquire phase tracks with comparator nulled; convert phase compares.
// - Start needs chip select, read and high byte select all low.
// - Busy is low during a conversion, high otherwise.
// - High byte select blocks start and routes upper bits low.
// - A read that starts a conversion returns the previous result.
module sar_conversion_sequencer
  import sar_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Host strobes
  input  wire logic                  cs_n,
  input  wire logic                  rd_n,
  input  wire logic                  high_byte_select,
  input  wire logic                  bipolar,
  // Analog front end
  input  wire logic                  comp_in,
  output logic [sar_pkg::RES_W-1:0]  dac_trial,
  output logic                       track_en,
  output logic                       comp_null,
  // Data pins and status
  output logic [sar_pkg::RES_W-1:0]  result_bits,
  output logic                       data_oe,
  output logic                       busy_n,
  // Result stream
  output logic                       res_valid,
  output logic [sar_pkg::RES_W-1:0]  res_data,
  input  wire logic                  res_ready
);
  import sar_pkg::*;

  typedef struct packed {
    seq_state_t        state;
    logic [CNT_W-1:0]  cnt;
    logic [IDX_W-1:0]  idx;
    logic [RES_W-1:0]  sar;
    logic [RES_W-1:0]  trial;
    logic [RES_W-1:0]  latch;
    logic [RES_W-1:0]  pins;
    logic              start_prev;
  } seq_st_t;

  seq_st_t          st_q;
  seq_st_t          st_d;
  logic             start_req;
  logic             start_edge;
  logic             tick;
  logic [RES_W-1:0] sar_dec;
  logic [RES_W-1:0] fmt_word;

  stream_if #(.W(RES_W)) push_if ();
  stream_if #(.W(RES_W)) pop_if ();

  // ****************************************************************
  // Start decode and bit-rate divider
  // ****************************************************************
  assign start_req  = !cs_n && !rd_n && !high_byte_select;
  assign start_edge = start_req && !st_q.start_prev;
  assign tick       = (st_q.state == S_CONV) && (st_q.cnt == CNT_LAST);
  assign data_oe    = !cs_n && !rd_n;

  always_comb begin
    sar_dec          = st_q.sar;
    sar_dec[st_q.idx] = comp_in;
  end

  assign fmt_word = {st_q.sar[RES_W-1] ^ bipolar, st_q.sar[RES_W-2:0]};

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    st_d            = st_q;
    st_d.start_prev = start_req;
    case (st_q.state)
      S_IDLE: begin
        if (start_edge) begin
          st_d.state = S_CONV;
          st_d.sar   = ZERO_WORD;
          st_d.trial = MSB_MASK;
          st_d.idx   = MSB_IDX;
          st_d.cnt   = CNT_ZERO;
        end
      end
      S_CONV: begin
        st_d.cnt = tick ? CNT_ZERO : st_q.cnt + 1'b1;
        if (tick) begin
          st_d.sar = sar_dec;
          if (st_q.idx == LSB_IDX) begin
            st_d.trial = sar_dec;
            st_d.state = S_LOAD;
          end else begin
            st_d.idx   = st_q.idx - 1'b1;
            st_d.trial = sar_dec | (RES_W'(1) << (st_q.idx - 1'b1));
          end
        end
      end
      S_LOAD: begin
        if (push_if.ready) begin
          st_d.latch = fmt_word;
          st_d.state = S_IDLE;
        end
      end
      default: begin
        st_d.state = S_IDLE;
      end
    endcase
    // Latch only moves in load, so a starting read sees the old word
    if (high_byte_select) begin
      st_d.pins = {st_d.latch[11:8], LOW_NIB, st_d.latch[11:8]};
    end else begin
      st_d.pins = st_d.latch;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.state <= S_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs and result FIFO
  // ****************************************************************
  assign busy_n      = (st_q.state == S_IDLE);
  assign track_en    = (st_q.state == S_IDLE);
  assign comp_null   = (st_q.state == S_IDLE);
  assign dac_trial   = st_q.trial;
  assign result_bits = st_q.pins;

  assign push_if.valid = (st_q.state == S_LOAD);
  assign push_if.data  = fmt_word;
  assign res_valid     = pop_if.valid;
  assign res_data      = pop_if.data;
  assign pop_if.ready  = res_ready;

  result_fifo #(.W(RES_W), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr      (push_if),
    .rd      (pop_if)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_start_clears: assert property (
    (st_q.state == S_IDLE) && start_edge |=>
      (st_q.sar == ZERO_WORD) && (st_q.trial == MSB_MASK) && !busy_n)
    else $error("start did not clear approximation register");

  chk_no_restart: assert property (
    (st_q.state == S_CONV) && start_edge && !tick |=>
      $stable(st_q.idx) && $stable(st_q.sar))
    else $error("running conversion disturbed by start");

  chk_bit_order: assert property (
    tick && (st_q.idx != LSB_IDX) |=> st_q.idx == $past(st_q.idx) - 1'b1)
    else $error("bit index not stepping down");

  chk_bit_decide: assert property (
    tick |=> st_q.sar[$past(st_q.idx)] == $past(comp_in))
    else $error("bit decision not taken from comparator");

  chk_latch_load: assert property (
    (st_q.state == S_LOAD) && push_if.ready |=>
      st_q.latch == ($past(bipolar) ? ($past(st_q.sar) ^ MSB_MASK)
                                    : $past(st_q.sar)))
    else $error("output latch not loaded with formatted word");

  chk_busy_level: assert property (
    (st_q.state == S_IDLE) && start_edge |=> !busy_n [*8])
    else $error("busy not low during conversion");

  chk_phase_out: assert property (
    (st_q.state == S_CONV) |-> !track_en && !comp_null)
    else $error("front end not in convert phase");

  chk_hbs_blocks: assert property (
    (st_q.state == S_IDLE) && high_byte_select |=> st_q.state == S_IDLE)
    else $error("start accepted with high byte select high");

  chk_hbs_mux: assert property (
    high_byte_select |=>
      result_bits == {st_q.latch[11:8], LOW_NIB, st_q.latch[11:8]})
    else $error("high byte routing wrong");

  chk_hold_latch: assert property (
    (st_q.state == S_CONV) |=> $stable(st_q.latch))
    else $error("output latch changed during conversion");

  cov_conversion: cover property (
    (st_q.state == S_LOAD) ##1 (st_q.state == S_IDLE));
  cov_bipolar: cover property (
    (st_q.state == S_LOAD) && push_if.ready && bipolar);
  cov_fifo_stall: cover property (
    (st_q.state == S_LOAD) && !push_if.ready);
endmodule
`default_nettype wire

// file: test/analog_front_model.sv
// Comparator stand-in: decides each trial word against a target code.
// Assumes the trial word and track flag are registered on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
  import sar_pkg::*;
(
  // Clock
  input  wire logic                 sys_clk,
  // Trial word and target
  input  wire logic [sar_pkg::RES_W-1:0] dac_trial,
  input  wire logic                 track_en,
  input  wire logic [sar_pkg::RES_W-1:0] target,
  // Decision
  output logic                      comp_in
);
  logic tog_q = 1'b0;
  always_ff @(posedge sys_clk) begin
    tog_q <= ~tog_q;
  end
  // Nulled comparator gives no usable decision while tracking
  assign comp_in = track_en ? tog_q : (target >= dac_trial);
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench of the conversion sequencer.
// Assumes package, stream interface, FIFO and comparator model compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sar_pkg::*;
  localparam int CONV_CYC = 12 * BIT_CYC;
  logic             sys_clk, rst_n, cs_n, rd_n, high_byte_select, bipolar;
  logic             comp_in, track_en, comp_null, data_oe, busy_n;
  logic             res_valid, res_ready;
  logic [RES_W-1:0] dac_trial, result_bits, res_data, target, last_q;
  logic [RES_W-1:0] pend[$];
  int               mismatches, total_checks, len, got;

  sar_conversion_sequencer i_sar_conversion_sequencer (
    .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
    .high_byte_select(high_byte_select), .bipolar(bipolar),
    .comp_in(comp_in), .dac_trial(dac_trial), .track_en(track_en),
    .comp_null(comp_null), .result_bits(result_bits), .data_oe(data_oe),
    .busy_n(busy_n), .res_valid(res_valid), .res_data(res_data),
    .res_ready(res_ready));
  analog_front_model i_analog_front_model (
    .sys_clk(sys_clk), .dac_trial(dac_trial), .track_en(track_en),
    .target(target), .comp_in(comp_in));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [RES_W-1:0] exp_code(input logic [RES_W-1:0] t,
                                                 input logic b);
    return b ? (t ^ MSB_MASK) : t;
  endfunction
  task automatic strobe(input logic lvl);
    cs_n = lvl;
    rd_n = lvl;
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // One conversion, optional restart attempt or stall on full buffer
  // ****************************************************************
  task automatic conv(input logic [RES_W-1:0] t, input logic b,
                      input logic again, input logic stall);
    target = t;
    bipolar = b;
    strobe(1'b0);
    len = 0;
    tick(2);
    check(busy_n === 1'b0, "busy not low after start");
    check(data_oe === 1'b1, "drivers off at start");
    check(dac_trial === MSB_MASK, "first trial not top bit");
    check(!track_en && !comp_null, "still in acquire");
    check(result_bits === last_q, "old result not shown");
    strobe(1'b1);
    pend.push_back(exp_code(t, b));
    if (again) begin
      tick(25);
      strobe(1'b0);
      tick(1);
      strobe(1'b1);
      len = 26;
      check(result_bits === last_q, "latch moved mid conversion");
    end
    if (stall) begin
      tick(3 * CONV_CYC);
      check(busy_n === 1'b0, "finished into full buffer");
      check(result_bits === last_q, "latch moved while stalled");
      return;
    end
    while (busy_n !== 1'b1 && len < 4 * CONV_CYC) begin
      tick(1);
      len++;
    end
    check(len >= CONV_CYC - 3 && len <= CONV_CYC + 2, "busy span");
    last_q = exp_code(t, b);
    tick(ACQ_NS / CLK_NS);
    check(result_bits === last_q, "result word wrong");
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #(CLK_NS * 4000);
    mismatches++;
    $display("Error %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    strobe(1'b1);
    high_byte_select = 1'b0;
    bipolar = 1'b0;
    target = ZERO_WORD;
    res_ready = 1'b0;
    last_q = ZERO_WORD;
    mismatches = 0;
    total_checks = 0;
    void'($urandom(32'he6bb0f6e));
    tick(2);
    rst_n = 1'b1;
    tick(1);
    check(busy_n === 1'b1 && data_oe === 1'b0, "idle outputs");
    conv(12'h000, 1'b0, 1'b0, 1'b0);
    conv(12'hfff, 1'b0, 1'b0, 1'b0);
    conv(12'h800, 1'b1, 1'b0, 1'b0);
    conv(12'h7ff, 1'b1, 1'b1, 1'b0);
    repeat (4) conv(RES_W'($urandom), 1'($urandom), 1'b0, 1'b0);
    // Upper byte select refuses start and mirrors the top nibble
    high_byte_select = 1'b1;
    strobe(1'b0);
    tick(5);
    check(busy_n === 1'b1, "start not refused");
    check(result_bits === {last_q[11:8], LOW_NIB, last_q[11:8]},
          "byte routing wrong");
    strobe(1'b1);
    tick(1);
    high_byte_select = 1'b0;
    tick(ACQ_NS / CLK_NS);
    conv(RES_W'($urandom), 1'($urandom), 1'b0, 1'b1);
    // Drain the buffer; the stalled result follows the first eight
    res_ready = 1'b1;
    got = 0;
    for (int i = 0; i < 40 * FIFO_DEPTH && got <= FIFO_DEPTH; i++) begin
      if (res_valid === 1'b1) begin
        check(res_data === pend[got], "buffer word wrong");
        got++;
      end
      tick(1);
    end
    check(got == FIFO_DEPTH + 1, "buffer count wrong");
    check(busy_n === 1'b1, "stall not released");
    check(result_bits === pend[FIFO_DEPTH], "final load wrong");
    report_and_stop();
  end
endmodule
`default_nettype wire
